// ---- sim/backplane_partner.sv ----
// Purpose: another repeater sharing the backplane
// Assumes: shared lines pulled up; own clock 48 ns, only within frames
// Notes:   tasks are called from the bench
`timescale 1ns/10ps
module backplane_partner (
    input  wire logic claim_wire,
    output logic      claim_oe,
    output logic      data_oe,
    output logic      col_oe,
    output logic      cfs_oe,
    output logic      clk,
    output logic      clk_oe
);
    initial begin
        claim_oe = 1'b0;
        data_oe  = 1'b0;
        col_oe   = 1'b0;
        cfs_oe   = 1'b0;
        clk      = 1'b0;
        clk_oe   = 1'b0;
    end

    // a frame of constant bits; claim and data lines only pulled low or released, clock driven both ways
    task automatic send_frame(input logic level, input int periods);
        int i;
        wait (claim_wire === 1'b1);
        claim_oe = 1'b1;
        data_oe  = ~level;
        clk_oe   = 1'b1;
        #200;
        for (i = 0; i < periods; i++) begin
            #24 clk = 1'b1;
            #24 clk = 1'b0;
        end
        #200;
        clk_oe   = 1'b0;
        data_oe  = 1'b0;
        claim_oe = 1'b0;
    endtask : send_frame

    task automatic pull_col(input int span);
        col_oe = 1'b1;
        cfs_oe = 1'b1;
        #(span);
        col_oe = 1'b0;
        cfs_oe = 1'b0;
    endtask : pull_col
endmodule : backplane_partner

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the backplane port
// Assumes: lines pulled up; partner repeater clocks its own frames
// Notes:   led slot shortened to 8 cycles
`timescale 1ns/10ps
module tb_top;
    localparam int SLOT = 8;
    logic        MCLK, RESETN, MODE_ASYNC, TX_REQ, TX_DATA, COL_REQ;
    logic [1:0]  LED_MODE, aui_seen;
    logic [19:0] TP_STATUS;
    logic [4:0]  AUI_STATUS;
    logic        CLAIM_OUT, CLAIM_OE, DATA_OUT, DATA_OE, BCLK_OUT, BCLK_OE;
    logic        COL_OUT, COL_OE, CFS_OUT, CFS_OE, RX_DATA, RX_VALID, RX_ACTIVE;
    logic        EXT_DRIVER_ENABLE_N, BUS_COLLISION, SYNC_MODE, AUI_LED_OUT, AUI_LED_OE;
    logic [3:0]  TP_LED_OUT, TP_LED_OE, seen_hi, seen_lo;
    logic        p_claim, p_data, p_col, p_cfs, p_clk, p_clk_oe;
    wire         claim_w = !(CLAIM_OE || p_claim);
    wire         data_w  = !(DATA_OE || p_data);
    wire         col_w   = !(COL_OE || p_col);
    wire         cfs_w   = !(CFS_OE || p_cfs);
    wire         bclk_w  = BCLK_OE ? BCLK_OUT
                         : !MODE_ASYNC ? MCLK : (p_clk_oe & p_clk);
    int          errors, n_compared, n_valid;

    repeater_backplane_port #(.LED_SLOT_CYCLES(SLOT)) i_dut (
        .MCLK(MCLK), .RESETN(RESETN), .BCLK_IN(bclk_w), .MODE_ASYNC(MODE_ASYNC),
        .LED_MODE(LED_MODE), .TX_REQ(TX_REQ), .TX_DATA(TX_DATA), .COL_REQ(COL_REQ),
        .TP_STATUS(TP_STATUS), .AUI_STATUS(AUI_STATUS), .CLAIM_IN(claim_w),
        .CLAIM_OUT(CLAIM_OUT), .CLAIM_OE(CLAIM_OE), .DATA_IN(data_w),
        .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .BCLK_OUT(BCLK_OUT), .BCLK_OE(BCLK_OE),
        .EXT_DRIVER_ENABLE_N(EXT_DRIVER_ENABLE_N), .COL_IN(col_w), .COL_OUT(COL_OUT),
        .COL_OE(COL_OE), .CFS_IN(cfs_w), .CFS_OUT(CFS_OUT), .CFS_OE(CFS_OE),
        .RX_DATA(RX_DATA), .RX_VALID(RX_VALID), .RX_ACTIVE(RX_ACTIVE),
        .BUS_COLLISION(BUS_COLLISION), .SYNC_MODE(SYNC_MODE), .TP_LED_OUT(TP_LED_OUT),
        .TP_LED_OE(TP_LED_OE), .AUI_LED_OUT(AUI_LED_OUT), .AUI_LED_OE(AUI_LED_OE)
    );

    backplane_partner i_partner (
        .claim_wire(claim_w), .claim_oe(p_claim), .data_oe(p_data), .col_oe(p_col),
        .cfs_oe(p_cfs), .clk(p_clk), .clk_oe(p_clk_oe)
    );

    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end

    always @(posedge MCLK) begin
        if (RX_VALID === 1'b1) n_valid++;
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic wait_claim(input logic level);
        int k;
        for (k = 0; k < 12 && CLAIM_OE !== level; k++) @(negedge MCLK);
    endtask : wait_claim

    task automatic do_reset(input logic [1:0] led);
        RESETN = 1'b0;
        LED_MODE = led;
        repeat (5) @(negedge MCLK);
        chk({CLAIM_OE, DATA_OE, COL_OE, CFS_OE}, 4'h0);
        RESETN = 1'b1;
        repeat (5) @(negedge MCLK);
    endtask : do_reset

    task automatic t_transmit();
        logic b0;
        TX_REQ = 1'b1;
        wait_claim(1'b1);
        chk({CLAIM_OE, CFS_OE, EXT_DRIVER_ENABLE_N, BCLK_OE}, 4'hd);
        repeat (3) @(negedge MCLK);
        chk({CLAIM_OUT, DATA_OUT, COL_OUT, CFS_OUT}, 4'h0);
        chk({DATA_OE, EXT_DRIVER_ENABLE_N}, 4'h2);
        TX_DATA = 1'b1;
        b0 = BCLK_OUT;
        repeat (3) @(negedge MCLK);
        chk({DATA_OE, EXT_DRIVER_ENABLE_N, BCLK_OUT}, {3'h0, ~b0});
        COL_REQ = 1'b1;
        repeat (5) @(negedge MCLK);
        chk({COL_OE, BUS_COLLISION}, 4'h3);
        COL_REQ = 1'b0;
        repeat (5) @(negedge MCLK);
        chk({COL_OE, BUS_COLLISION}, 4'h0);
        TX_REQ = 1'b0;
        TX_DATA = 1'b0;
        repeat (3) @(negedge MCLK);
        chk({CLAIM_OE, DATA_OE, BCLK_OE, EXT_DRIVER_ENABLE_N}, 4'h1);
    endtask : t_transmit

    task automatic t_receive(input logic level);
        n_valid = 0;
        fork
            i_partner.send_frame(level, 48);
            begin
                wait (claim_w === 1'b0);
                repeat (6) @(negedge MCLK);
                TX_REQ = 1'b1;
                repeat (4) @(negedge MCLK);
                chk({RX_ACTIVE, CLAIM_OE, BCLK_OE}, 4'h4);
            end
        join
        chk({RX_DATA, n_valid > 0}, {level, 1'b1});
        wait_claim(1'b1);
        chk({CLAIM_OE, RX_ACTIVE}, 4'h2);
        TX_REQ = 1'b0;
        wait_claim(1'b0);
        repeat (3) @(negedge MCLK);
    endtask : t_receive

    task automatic t_remote_col();
        fork
            i_partner.pull_col(1000);
            begin
                repeat (6) @(negedge MCLK);
                chk(BUS_COLLISION, 1'b1);
            end
        join
        repeat (5) @(negedge MCLK);
        chk(BUS_COLLISION, 1'b0);
    endtask : t_remote_col

    task automatic t_sync();
        MODE_ASYNC = 1'b0;
        repeat (5) @(negedge MCLK);
        chk(SYNC_MODE, 1'b0);
        do_reset(2'h0);
        chk(SYNC_MODE, 1'b1);
        TX_REQ = 1'b1;
        wait_claim(1'b1);
        repeat (3) @(negedge MCLK);
        chk({CLAIM_OE, EXT_DRIVER_ENABLE_N, BCLK_OE}, 4'h4);
        TX_REQ = 1'b0;
        wait_claim(1'b0);
        MODE_ASYNC = 1'b1;
        do_reset(2'h0);
        chk(SYNC_MODE, 1'b0);
    endtask : t_sync

    task automatic t_leds(input logic [1:0] mode, input logic [3:0] exp);
        int k;
        TP_STATUS = 20'hfffff;
        AUI_STATUS = 5'h1f;
        do_reset(mode);
        seen_hi = 4'h0;
        seen_lo = 4'h0;
        aui_seen = 2'h0;
        for (k = 0; k < 3 * SLOT; k++) begin
            @(negedge MCLK);
            seen_hi |= TP_LED_OE & TP_LED_OUT;
            seen_lo |= TP_LED_OE & ~TP_LED_OUT;
            aui_seen |= {AUI_LED_OE & AUI_LED_OUT, AUI_LED_OE & ~AUI_LED_OUT};
        end
        chk(seen_hi, exp);
        chk(seen_lo, exp);
        chk(aui_seen, exp[1:0]);
    endtask : t_leds

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        RESETN = 1'b0;
        MODE_ASYNC = 1'b1;
        LED_MODE = 2'h0;
        TX_REQ = 1'b0;
        TX_DATA = 1'b0;
        COL_REQ = 1'b0;
        TP_STATUS = 20'h0;
        AUI_STATUS = 5'h0;
        errors = 0;
        n_compared = 0;
        n_valid = 0;
        do_reset(2'h0);
        chk({EXT_DRIVER_ENABLE_N, RX_DATA, BCLK_OE, SYNC_MODE}, 4'hc);
        t_transmit();
        t_receive(1'b0);
        t_receive(1'b1);
        t_remote_col();
        t_sync();
        t_leds(2'h0, 4'hf);
        t_leds(2'h3, 4'h0);
        close_out();
    end
endmodule : tb_top

// ---- verilog/backplane_link_if.sv ----
// Purpose: carrier between core and link-clock receiver
// Assumes: receiver on backplane clock, core on MCLK
// Notes:   rx_toggle flips once per captured bit
`timescale 1ns/10ps
interface backplane_link_if;
    logic rx_bit;
    logic rx_toggle;
    logic receiving;
    logic own_tx;
    modport core (input rx_bit, input rx_toggle, input receiving, output own_tx);
    modport link (output rx_bit, output rx_toggle, output receiving, input own_tx);
endinterface : backplane_link_if

// ---- verilog/backplane_receiver.sv ----
// Purpose: samples the backplane data line on the backplane clock
// Assumes: clock runs only during a transmission in asynchronous mode
// Notes:   nothing here relies on an edge outside a frame
`timescale 1ns/10ps
module backplane_receiver (
    input  wire logic       bclk,
    input  wire logic       RESETN,
    input  wire logic       claim_in,
    input  wire logic       data_in,
    backplane_link_if.link  lk
);
    logic claim_s1;
    logic claim_s2;
    logic data_s1;
    logic data_s2;
    logic own_s1;
    logic own_s2;
    logic rx_bit;
    logic rx_toggle;
    logic receiving;
    logic next_rx_bit;
    logic next_rx_toggle;
    logic next_receiving;

    always_comb begin
        next_receiving = !claim_s2 && !own_s2;
        next_rx_bit    = rx_bit;
        next_rx_toggle = rx_toggle;
        if (next_receiving) begin
            next_rx_bit    = data_s2;
            next_rx_toggle = !rx_toggle;
        end
    end

    always_ff @(posedge bclk or negedge RESETN) begin
        if (!RESETN) begin
            claim_s1  <= 1'b1;
            claim_s2  <= 1'b1;
            data_s1   <= 1'b1;
            data_s2   <= 1'b1;
            own_s1    <= 1'b0;
            own_s2    <= 1'b0;
            rx_bit    <= 1'b1;
            rx_toggle <= 1'b0;
            receiving <= 1'b0;
        end else begin
            claim_s1  <= claim_in;
            claim_s2  <= claim_s1;
            data_s1   <= data_in;
            data_s2   <= data_s1;
            own_s1    <= lk.own_tx;
            own_s2    <= own_s1;
            rx_bit    <= next_rx_bit;
            rx_toggle <= next_rx_toggle;
            receiving <= next_receiving;
        end
    end

    assign lk.rx_bit    = rx_bit;
    assign lk.rx_toggle = rx_toggle;
    assign lk.receiving = receiving;
endmodule : backplane_receiver

// ---- verilog/repeater_backplane_consts.svh ----
// Purpose: constants for the backplane port
// Assumes: core clock of 10 MHz
// Notes:   times in their own unit, counts derived from them
`ifndef REPEATER_BACKPLANE_CONSTS_SVH
`define REPEATER_BACKPLANE_CONSTS_SVH

`define BP_CORE_CLOCK_MHZ   10
`define BP_LED_SLOT_US      1000
`define BP_LED_SLOT_CYCLES  (`BP_LED_SLOT_US * `BP_CORE_CLOCK_MHZ)

// twisted-pair port status bit positions
`define BP_TP_RX            0
`define BP_TP_TX            1
`define BP_TP_LINK          2
`define BP_TP_POLARITY      3
`define BP_TP_PARTITION     4

// attachment port status bit positions
`define BP_AUI_RX           0
`define BP_AUI_TX           1
`define BP_AUI_JABBER       2
`define BP_AUI_COLLISION    3
`define BP_AUI_PARTITION    4

`define BP_STATUS_WIDTH     5
`define BP_TP_PORTS         4
`define BP_LED_MODE_OFF     2'h3

`endif

// ---- verilog/repeater_backplane_pkg.sv ----
// Purpose: types for the backplane port
// Assumes: nothing
// Notes:   transmit states in gray order
package repeater_backplane_pkg;
    typedef enum logic [1:0] {
        TX_IDLE    = 2'h0,
        TX_CLAIM   = 2'h1,
        TX_SEND    = 2'h3,
        TX_RELEASE = 2'h2
    } tx_state_type;
endpackage : repeater_backplane_pkg

// ---- verilog/repeater_backplane_port.sv ----
// Purpose: backplane port joining several hub repeaters into one
// Assumes: MCLK 10 MHz; backplane lines pulled up outside
// Notes:   open-drain lines are driven low or released only
//
// What this block does
// - asynchronous mode: clock line driven only while a repeater sends
// - sender in asynchronous mode drives its own clock onto the clock line
// - listeners follow the sender's clock until that transmission ends
// - mode pin high or open selects asynchronous, low selects synchronous
// - claim line asserted to own the bus; only the owner drives data
// - data line carries repeated frame data from owner to all others
// - driver enable low for the whole own transmission, high otherwise
// - collisions exchanged over collision line and flag sense line
// - each tp led pin alternates two leds reporting five conditions
// - attachment led pin alternates two leds reporting five conditions
// - mode inputs sampled at reset to fix backplane and led modes
`timescale 1ns/10ps
`include "repeater_backplane_consts.svh"
module repeater_backplane_port #(
    parameter int LED_SLOT_CYCLES = `BP_LED_SLOT_CYCLES
) (
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        BCLK_IN,
    input  wire logic        MODE_ASYNC,
    input  wire logic [1:0]  LED_MODE,
    input  wire logic        TX_REQ,
    input  wire logic        TX_DATA,
    input  wire logic        COL_REQ,
    input  wire logic [19:0] TP_STATUS,
    input  wire logic [4:0]  AUI_STATUS,
    input  wire logic        CLAIM_IN,
    output logic             CLAIM_OUT,
    output logic             CLAIM_OE,
    input  wire logic        DATA_IN,
    output logic             DATA_OUT,
    output logic             DATA_OE,
    output logic             BCLK_OUT,
    output logic             BCLK_OE,
    output logic             EXT_DRIVER_ENABLE_N,
    input  wire logic        COL_IN,
    output logic             COL_OUT,
    output logic             COL_OE,
    input  wire logic        CFS_IN,
    output logic             CFS_OUT,
    output logic             CFS_OE,
    output logic             RX_DATA,
    output logic             RX_VALID,
    output logic             RX_ACTIVE,
    output logic             BUS_COLLISION,
    output logic             SYNC_MODE,
    output logic [3:0]       TP_LED_OUT,
    output logic [3:0]       TP_LED_OE,
    output logic             AUI_LED_OUT,
    output logic             AUI_LED_OE
);
    backplane_link_if lk ();

    backplane_receiver u_receiver (
        .bclk     (BCLK_IN),
        .RESETN   (RESETN),
        .claim_in (CLAIM_IN),
        .data_in  (DATA_IN),
        .lk       (lk.link)
    );

    repeater_backplane_pkg::tx_state_type state;
    repeater_backplane_pkg::tx_state_type next_state;
    logic [1:0]  mode_s1;
    logic [1:0]  mode_s2;
    logic [1:0]  led_mode_s1;
    logic [1:0]  led_mode_s;
    logic [2:0]  line_s1;
    logic [2:0]  line_s2;
    logic [2:0]  tog_s;
    logic [1:0]  recv_s;
    logic        mode_done;
    logic        mode_async;
    logic [1:0]  led_mode;
    logic [13:0] slot_count;
    logic        phase;
    logic        claiming;
    logic        bus_free;
    logic [1:0]  next_pair [5];
    logic        next_mode_done;
    logic        next_mode_async;
    logic [1:0]  next_led_mode;
    logic [13:0] next_slot_count;
    logic        next_phase;
    logic        next_claim_oe;
    logic        next_data_oe;
    logic        next_bclk_oe;
    logic        next_bclk_out;
    logic        next_col_oe;
    logic        next_cfs_oe;
    logic        next_rx_valid;
    logic        next_rx_data;

    // two-led drive: {oe, level}; high phase lights activity, low phase faults
    function automatic logic [1:0] led_drive(input logic [4:0] st, input logic ph,
                                             input logic off, input logic aui);
        logic good;
        logic bad;
        good = aui ? (st[`BP_AUI_RX] | st[`BP_AUI_TX])
                   : (st[`BP_TP_RX] | st[`BP_TP_TX] | st[`BP_TP_LINK]);
        bad  = aui ? (st[`BP_AUI_JABBER] | st[`BP_AUI_COLLISION] | st[`BP_AUI_PARTITION])
                   : (st[`BP_TP_POLARITY] | st[`BP_TP_PARTITION]);
        if (off)
            return 2'h0;
        return ph ? {good, 1'b1} : {bad, 1'b0};
    endfunction : led_drive

    assign claiming = (state == repeater_backplane_pkg::TX_CLAIM)
                   || (state == repeater_backplane_pkg::TX_SEND);
    assign bus_free = line_s2[0];
    assign lk.own_tx = CLAIM_OE;

    always_comb begin
        next_mode_done  = mode_s2[1];
        next_mode_async = (mode_s2[1] && !mode_done) ? mode_s2[0] : mode_async;
        next_led_mode   = (mode_s2[1] && !mode_done) ? led_mode_s : led_mode;
        next_slot_count = slot_count + 14'h1;
        next_phase      = phase;
        if (slot_count >= 14'(LED_SLOT_CYCLES - 1)) begin
            next_slot_count = 14'h0;
            next_phase      = !phase;
        end
        next_state = state;
        case (state)
            repeater_backplane_pkg::TX_IDLE: begin
                if (TX_REQ && bus_free && mode_done)
                    next_state = repeater_backplane_pkg::TX_CLAIM;
            end
            repeater_backplane_pkg::TX_CLAIM: begin
                next_state = TX_REQ ? repeater_backplane_pkg::TX_SEND
                                    : repeater_backplane_pkg::TX_RELEASE;
            end
            repeater_backplane_pkg::TX_SEND: begin
                if (!TX_REQ)
                    next_state = repeater_backplane_pkg::TX_RELEASE;
            end
            repeater_backplane_pkg::TX_RELEASE: begin
                next_state = repeater_backplane_pkg::TX_IDLE;
            end
            default: begin
                next_state = repeater_backplane_pkg::TX_IDLE;
            end
        endcase
        next_claim_oe = (next_state == repeater_backplane_pkg::TX_CLAIM)
                     || (next_state == repeater_backplane_pkg::TX_SEND);
        next_data_oe  = (next_state == repeater_backplane_pkg::TX_SEND) && !TX_DATA;
        next_bclk_oe  = next_claim_oe && mode_async;
        next_bclk_out = next_bclk_oe ? !BCLK_OUT : 1'b0;
        next_col_oe   = next_claim_oe && COL_REQ;
        next_cfs_oe   = next_claim_oe;
        next_rx_valid = (tog_s[1] ^ tog_s[2]) && !claiming;
        next_rx_data  = next_rx_valid ? lk.rx_bit : RX_DATA;
        for (int i = 0; i < `BP_TP_PORTS; i++)
            next_pair[i] = led_drive(TP_STATUS[i*5 +: 5], phase,
                                     led_mode == `BP_LED_MODE_OFF, 1'b0);
        next_pair[4] = led_drive(AUI_STATUS, phase, led_mode == `BP_LED_MODE_OFF, 1'b1);
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state               <= repeater_backplane_pkg::TX_IDLE;
            mode_s1             <= 2'h0;
            mode_s2             <= 2'h0;
            led_mode_s1         <= 2'h0;
            led_mode_s          <= 2'h0;
            line_s1             <= 3'h7;
            line_s2             <= 3'h7;
            tog_s               <= 3'h0;
            recv_s              <= 2'h0;
            mode_done           <= 1'b0;
            mode_async          <= 1'b1;
            led_mode            <= 2'h0;
            slot_count          <= 14'h0;
            phase               <= 1'b0;
            CLAIM_OUT           <= 1'b0;
            CLAIM_OE            <= 1'b0;
            DATA_OUT            <= 1'b0;
            DATA_OE             <= 1'b0;
            BCLK_OUT            <= 1'b0;
            BCLK_OE             <= 1'b0;
            EXT_DRIVER_ENABLE_N <= 1'b1;
            COL_OUT             <= 1'b0;
            COL_OE              <= 1'b0;
            CFS_OUT             <= 1'b0;
            CFS_OE              <= 1'b0;
            RX_DATA             <= 1'b1;
            RX_VALID            <= 1'b0;
            RX_ACTIVE           <= 1'b0;
            BUS_COLLISION       <= 1'b0;
            SYNC_MODE           <= 1'b0;
            TP_LED_OUT          <= 4'h0;
            TP_LED_OE           <= 4'h0;
            AUI_LED_OUT         <= 1'b0;
            AUI_LED_OE          <= 1'b0;
        end else begin
            state               <= next_state;
            mode_s1             <= {1'b1, MODE_ASYNC}; // top bit marks a filled stage
            mode_s2             <= mode_s1;
            led_mode_s1         <= LED_MODE;
            led_mode_s          <= led_mode_s1;
            line_s1             <= {CFS_IN, COL_IN, CLAIM_IN};
            line_s2             <= line_s1;
            tog_s               <= {tog_s[1:0], lk.rx_toggle};
            recv_s              <= {recv_s[0], lk.receiving};
            mode_done           <= next_mode_done;
            mode_async          <= next_mode_async;
            led_mode            <= next_led_mode;
            slot_count          <= next_slot_count;
            phase               <= next_phase;
            CLAIM_OUT           <= 1'b0;
            CLAIM_OE            <= next_claim_oe;
            DATA_OUT            <= 1'b0;
            DATA_OE             <= next_data_oe;
            BCLK_OUT            <= next_bclk_out;
            BCLK_OE             <= next_bclk_oe;
            EXT_DRIVER_ENABLE_N <= !next_claim_oe;
            COL_OUT             <= 1'b0;
            COL_OE              <= next_col_oe;
            CFS_OUT             <= 1'b0;
            CFS_OE              <= next_cfs_oe;
            RX_DATA             <= next_rx_data;
            RX_VALID            <= next_rx_valid;
            RX_ACTIVE           <= recv_s[1] && !line_s2[0] && !claiming;
            BUS_COLLISION       <= !line_s2[1] || (!line_s2[2] && !claiming);
            SYNC_MODE           <= !mode_async;
            for (int i = 0; i < `BP_TP_PORTS; i++) begin
                TP_LED_OE[i]  <= next_pair[i][1];
                TP_LED_OUT[i] <= next_pair[i][0];
            end
            AUI_LED_OE          <= next_pair[4][1];
            AUI_LED_OUT         <= next_pair[4][0];
        end
    end

    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    a_driver_enable_tx: assert property (EXT_DRIVER_ENABLE_N == !claiming)
        else $error("driver enable not matching own transmission");
    a_data_needs_claim: assert property (DATA_OE |-> CLAIM_OE)
        else $error("data driven without claim");
    a_claim_waits_free: assert property ($rose(CLAIM_OE) |-> $past(bus_free))
        else $error("claim taken on a busy bus");
    a_clock_only_sending: assert property (BCLK_OE |-> CLAIM_OE && mode_async)
        else $error("clock driven while not sending");
    a_clock_toggles_out: assert property (BCLK_OE && $past(BCLK_OE)
        |-> BCLK_OUT != $past(BCLK_OUT))
        else $error("own clock not toggling");
    a_sync_mode_quiet: assert property (SYNC_MODE |-> !BCLK_OE)
        else $error("clock driven in synchronous mode");
    a_data_follows_tx: assert property (state == repeater_backplane_pkg::TX_SEND
        && TX_REQ && !TX_DATA |=> DATA_OE)
        else $error("low data bit not driven");
    a_lines_only_low: assert property (!CLAIM_OUT && !DATA_OUT && !COL_OUT && !CFS_OUT)
        else $error("shared line driven high");
    a_collision_drive: assert property (claiming && TX_REQ && COL_REQ
        && state == repeater_backplane_pkg::TX_SEND |=> COL_OE)
        else $error("collision not signalled");
    a_mode_held: assert property (mode_done && $past(mode_done)
        |-> $stable(mode_async) && $stable(led_mode))
        else $error("mode changed after reset");
    a_tp_led_high: assert property ($past(RESETN) && $past(phase)
        && $past(led_mode) != `BP_LED_MODE_OFF && $past(TP_STATUS[`BP_TP_LINK])
        |-> TP_LED_OE[0] && TP_LED_OUT[0])
        else $error("link led not lit");
    a_aui_led_low: assert property ($past(RESETN) && !$past(phase)
        && $past(led_mode) != `BP_LED_MODE_OFF && $past(AUI_STATUS[`BP_AUI_JABBER])
        |-> AUI_LED_OE && !AUI_LED_OUT)
        else $error("jabber led not lit");

    c_own_frame: cover property (state == repeater_backplane_pkg::TX_SEND ##1 state == repeater_backplane_pkg::TX_RELEASE);
    c_async_clock: cover property (BCLK_OE ##1 BCLK_OE);
    c_rx_bit: cover property (RX_VALID && RX_ACTIVE);
    c_collision: cover property (BUS_COLLISION && CLAIM_OE);
endmodule : repeater_backplane_port
